// ---- src/acr_control.sv ----
// Purpose: Control, result and input-disable registers of the 10-bit converter.
// Assumes: The conversion core returns offset-binary data with a one-cycle done strobe.
// Notes:   Register reads answer one cycle after the read strobe and are zero otherwise.
//
// Design decision made here: strobed register access.
`timescale 1ns/10ps
// Notes on behaviour
// [RULE1] Interrupt needs enable, global enable, done flag.
// [RULE2] Divider codes give 2,2,4,8,16,32,64,128.
// [RULE3] Right alignment: low byte 7:0, high 9:8.
// [RULE4] Left alignment: high byte 9:2, low 7:6.
// [RULE5] Differential channels give two's-complement results.
// [RULE6] Reading low byte locks both until high read.
// [RULE7] Software reads low byte before high byte.
// [RULE8] Result bytes are read-only and reset zero.
// [RULE9] Control B reserved bits read zero.
// [RULE10] Auto trigger starts on selected flag edge.
// [RULE11] Trigger select ignored while auto trigger off.
// [RULE12] Switching to a set source makes edge.
// [RULE13] Switching to free running makes no edge.
// [RULE14] Trigger select decodes eight documented sources.
// [RULE15] Disabled pin buffer reads its input zero.
// [RULE16] Software disables unused buffers to save power.
// [RULE17] Done flag sets on update, clears by vector/one.
// [RULE18] Writing auto trigger one enables edge starts.
// [RULE19] Alignment change alters result bytes at once.
// [RULE20] Start bit reads busy; writing zero ignored.
// [RULE21] Prescaler is counter enable; core is external.
module acr_control (
  input  wire logic       sys_clk,
  input  wire logic       reset,
  input  wire logic [7:0] regAddr,
  input  wire logic [7:0] regWrData,
  input  wire logic       regWrEn,
  input  wire logic       regRdEn,
  output logic      [7:0] regRdData,
  input  wire logic       globalIrqEnable,
  input  wire logic       irqVectorTaken,
  output logic            convIrq,
  input  wire logic [7:1] trigSrcFlags,
  output logic            coreEnable,
  output logic            coreStart,
  output logic      [4:0] coreChannel,
  output logic            coreClkEnable,
  input  wire logic [9:0] coreResult,
  input  wire logic       coreDone,
  input  wire logic [7:0] pinRaw,
  output logic      [7:0] pinValue,
  output logic      [7:0] bufferDisable
);
  logic             convEnable_q;
  logic             autoTrig_q;
  logic             doneFlag_q;
  logic             irqEnable_q;
  logic       [2:0] divSel_q;
  logic       [2:0] trigSel_q;
  logic             cmpMux_q;
  logic             leftAlign_q;
  logic       [4:0] channel_q;
  logic       [9:0] result_q;
  logic             lock_q;
  acr_pkg::acr_state_t state_q;
  acr_pkg::acr_state_t state_d;
  logic       [7:0] resLow;
  logic       [7:0] resHigh;
  logic       [7:0] ctrlA;
  logic       [7:0] ctrlB;
  logic       [7:0] rdMux;
  logic             wrCtrlA;
  logic             wrCtrlB;
  logic             wrChan;
  logic             wrBufDis;
  logic             rdLow;
  logic             rdHigh;
  logic             swStart;
  logic             trigEdge;
  logic             autoStart;
  logic             startConv;
  logic             busy;
  logic             acceptDone;
  logic             diffChan;
  logic       [9:0] resultFmt;
  logic             clkTick;

  // Address decode shared by the write and read paths.
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] target, input logic strobe);
    return strobe && (addr == target);
  endfunction : hit

  assign wrCtrlA  = hit(regAddr, acr_pkg::ADDR_CTRL_A,   regWrEn);
  assign wrCtrlB  = hit(regAddr, acr_pkg::ADDR_CTRL_B,   regWrEn);
  assign wrChan   = hit(regAddr, acr_pkg::ADDR_CHAN,     regWrEn);
  assign wrBufDis = hit(regAddr, acr_pkg::ADDR_BUF_DIS,  regWrEn);
  assign rdLow    = hit(regAddr, acr_pkg::ADDR_RES_LOW,  regRdEn);
  assign rdHigh   = hit(regAddr, acr_pkg::ADDR_RES_HIGH, regRdEn);

  assign busy     = (state_q == acr_pkg::ACR_CONVERT);

  acr_prescaler u_prescaler (
    .sys_clk (sys_clk),
    .reset   (reset),
    .divSel  (divSel_q),
    .tick    (clkTick)
  );

  acr_trigger u_trigger (
    .sys_clk  (sys_clk),
    .reset    (reset),
    .trigSel  (trigSel_q),
    .doneFlag (doneFlag_q),
    .srcFlags (trigSrcFlags),
    .trigEdge (trigEdge)
  );

  // Writing zero to the start bit is simply not a start request.
  assign swStart   = wrCtrlA && regWrData[acr_pkg::CA_START]; // [RULE20]
  // The selected edge counts only while auto triggering is on.
  assign autoStart = autoTrig_q && trigEdge; // [RULE10] [RULE11] [RULE18]
  assign startConv = convEnable_q && !busy && (swStart || autoStart); // [RULE12]
  // A result finishing while the bytes are locked is dropped, not queued.
  assign acceptDone = busy && coreDone && !lock_q; // [RULE6]

  always_comb begin
    state_d = state_q;
    case (state_q)
      acr_pkg::ACR_IDLE: begin
        if (startConv) state_d = acr_pkg::ACR_CONVERT;
      end
      acr_pkg::ACR_CONVERT: begin
        if (!convEnable_q || coreDone) state_d = acr_pkg::ACR_IDLE;
      end
      default: begin
        state_d = acr_pkg::ACR_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (reset) state_q <= acr_pkg::ACR_IDLE;
    else state_q <= state_d;
  end

  always_ff @(posedge sys_clk) begin
    if (reset) coreStart <= 1'b0;
    else coreStart <= startConv;
  end

  always_ff @(posedge sys_clk) begin
    if (reset) coreClkEnable <= 1'b0;
    else coreClkEnable <= clkTick; // [RULE21]
  end

  // Control A.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      convEnable_q <= 1'b0;
      autoTrig_q   <= 1'b0;
      irqEnable_q  <= 1'b0;
      divSel_q     <= acr_pkg::RESET_BYTE[2:0];
    end else if (wrCtrlA) begin
      convEnable_q <= regWrData[acr_pkg::CA_ENABLE];
      autoTrig_q   <= regWrData[acr_pkg::CA_AUTO];
      irqEnable_q  <= regWrData[acr_pkg::CA_IRQ_EN];
      divSel_q     <= regWrData[acr_pkg::CA_DIV_HI:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) coreEnable <= 1'b0;
    else if (wrCtrlA) coreEnable <= regWrData[acr_pkg::CA_ENABLE];
  end

  // A completing conversion wins over a clear in the same cycle.
  always_ff @(posedge sys_clk) begin
    if (reset) doneFlag_q <= 1'b0;
    else if (acceptDone) doneFlag_q <= 1'b1; // [RULE17]
    else if (irqVectorTaken || (wrCtrlA && regWrData[acr_pkg::CA_FLAG])) doneFlag_q <= 1'b0; // [RULE17]
  end

  always_ff @(posedge sys_clk) begin
    if (reset) convIrq <= 1'b0;
    else convIrq <= irqEnable_q && globalIrqEnable && doneFlag_q; // [RULE1]
  end

  // Control B: only the trigger select and comparator mux bit hold state.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      trigSel_q <= acr_pkg::TRIG_FREE;
      cmpMux_q  <= 1'b0;
    end else if (wrCtrlB) begin
      trigSel_q <= regWrData[acr_pkg::CB_TRIG_HI:0];
      cmpMux_q  <= regWrData[acr_pkg::CB_CMP_MUX];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      leftAlign_q <= 1'b0;
      channel_q   <= acr_pkg::RESET_BYTE[4:0];
    end else if (wrChan) begin
      leftAlign_q <= regWrData[acr_pkg::CH_LEFT];
      channel_q   <= regWrData[acr_pkg::CH_SEL_HI:0];
    end
  end

  // The core sees a channel change only between conversions.
  always_ff @(posedge sys_clk) begin
    if (reset) coreChannel <= acr_pkg::RESET_BYTE[4:0];
    else if (!busy) coreChannel <= channel_q;
  end

  always_ff @(posedge sys_clk) begin
    if (reset) bufferDisable <= acr_pkg::RESET_BYTE;
    else if (wrBufDis) bufferDisable <= regWrData;
  end

  // Inverting the sign bit turns offset binary into two's complement.
  assign diffChan  = (coreChannel >= acr_pkg::DIFF_FIRST) && (coreChannel <= acr_pkg::DIFF_LAST);
  assign resultFmt = diffChan ? {~coreResult[9], coreResult[8:0]} : coreResult; // [RULE5]

  always_ff @(posedge sys_clk) begin
    if (reset) result_q <= acr_pkg::RESET_RESULT; // [RULE8]
    else if (acceptDone) result_q <= resultFmt; // [RULE6]
  end

  // Reading the high byte releases the lock, so the read order matters.
  always_ff @(posedge sys_clk) begin
    if (reset) lock_q <= 1'b0;
    else if (rdHigh) lock_q <= 1'b0; // [RULE6] [RULE7]
    else if (rdLow) lock_q <= 1'b1; // [RULE6]
  end

  // Alignment is applied on read, so a change shows at once.
  always_comb begin
    if (leftAlign_q) begin
      resHigh = result_q[9:2]; // [RULE4] [RULE19]
      resLow  = {result_q[1:0], 6'h00}; // [RULE4]
    end else begin
      resHigh = {6'h00, result_q[9:8]}; // [RULE3] [RULE19]
      resLow  = result_q[7:0]; // [RULE3]
    end
  end

  assign ctrlA = {convEnable_q, busy, autoTrig_q, doneFlag_q, irqEnable_q, divSel_q}; // [RULE20]
  assign ctrlB = {1'b0, cmpMux_q, 3'h0, trigSel_q}; // [RULE9]

  always_comb begin
    rdMux = acr_pkg::RESET_BYTE;
    case (regAddr)
      acr_pkg::ADDR_RES_LOW:  rdMux = resLow;
      acr_pkg::ADDR_RES_HIGH: rdMux = resHigh;
      acr_pkg::ADDR_CTRL_A:   rdMux = ctrlA;
      acr_pkg::ADDR_CTRL_B:   rdMux = ctrlB;
      acr_pkg::ADDR_CHAN:     rdMux = {2'h0, leftAlign_q, channel_q};
      acr_pkg::ADDR_BUF_DIS:  rdMux = bufferDisable;
      default:                rdMux = acr_pkg::RESET_BYTE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (reset) regRdData <= acr_pkg::RESET_BYTE;
    else if (regRdEn) regRdData <= rdMux;
    else regRdData <= acr_pkg::RESET_BYTE;
  end

  // A disabled buffer leaves its pin value at zero.
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_pin
      always_ff @(posedge sys_clk) begin
        if (reset) pinValue[gi] <= 1'b0;
        else pinValue[gi] <= pinRaw[gi] && !bufferDisable[gi]; // [RULE15]
      end
    end
  endgenerate

  sequence s_low_read;
    rdLow;
  endsequence

  // A completion while the bytes are held is the case that must be dropped.
  sequence s_done_locked;
    lock_q && busy && coreDone;
  endsequence

  property p_irq;
    @(posedge sys_clk) disable iff (reset)
      ##1 (convIrq == $past(irqEnable_q && globalIrqEnable && doneFlag_q));
  endproperty
  a_irq: assert property (p_irq) else $error("Interrupt request does not follow its enables."); // [RULE1]

  property p_right_align;
    @(posedge sys_clk) disable iff (reset)
      (regRdEn && regAddr == acr_pkg::ADDR_RES_HIGH && !leftAlign_q) |=> (regRdData == {6'h00, $past(result_q[9:8])});
  endproperty
  a_right_align: assert property (p_right_align) else $error("Right-aligned high byte wrong."); // [RULE3]

  property p_left_align;
    @(posedge sys_clk) disable iff (reset)
      (regRdEn && regAddr == acr_pkg::ADDR_RES_LOW && leftAlign_q) |=> (regRdData == {$past(result_q[1:0]), 6'h00});
  endproperty
  a_left_align: assert property (p_left_align) else $error("Left-aligned low byte wrong."); // [RULE4]

  property p_lock_set;
    @(posedge sys_clk) disable iff (reset)
      s_low_read |=> lock_q;
  endproperty
  a_lock_set: assert property (p_lock_set) else $error("Low byte read did not lock the result."); // [RULE6]

  property p_lock;
    @(posedge sys_clk) disable iff (reset)
      s_done_locked |=> $stable(result_q) && !$rose(doneFlag_q);
  endproperty
  a_lock: assert property (p_lock) else $error("Result changed while low byte lock held."); // [RULE6]

  property p_reserved;
    @(posedge sys_clk) disable iff (reset)
      (regRdEn && regAddr == acr_pkg::ADDR_CTRL_B) |=> (regRdData[7] == 1'b0 && regRdData[5:3] == 3'h0);
  endproperty
  a_reserved: assert property (p_reserved) else $error("Reserved control bits read non-zero."); // [RULE9]

  property p_auto_start;
    @(posedge sys_clk) disable iff (reset)
      (autoTrig_q && trigEdge && convEnable_q && !busy) |=> (busy && coreStart);
  endproperty
  a_auto_start: assert property (p_auto_start) else $error("Trigger edge did not start a conversion."); // [RULE10]

  property p_no_auto;
    @(posedge sys_clk) disable iff (reset)
      (!autoTrig_q && !swStart && !busy) |=> !busy;
  endproperty
  a_no_auto: assert property (p_no_auto) else $error("Conversion began without a request."); // [RULE11]

  property p_done_set;
    @(posedge sys_clk) disable iff (reset)
      acceptDone |=> (doneFlag_q && result_q == $past(resultFmt)) ##1 (!busy || coreStart);
  endproperty
  a_done_set: assert property (p_done_set) else $error("Completion did not update flag and result."); // [RULE17]

  property p_pin_off;
    @(posedge sys_clk) disable iff (reset)
      (bufferDisable != 8'h00) |=> ((pinValue & $past(bufferDisable)) == 8'h00);
  endproperty
  a_pin_off: assert property (p_pin_off) else $error("Disabled pin input read non-zero."); // [RULE15]
endmodule : acr_control

// ---- src/acr_pkg.sv ----
// Purpose: Shared constants and types for the converter control and result registers.
// Assumes: Byte-wide register port, one system clock.
// Notes:   Offsets are byte addresses on the register port.
package acr_pkg;
  localparam logic [7:0] ADDR_RES_LOW   = 8'h78;
  localparam logic [7:0] ADDR_RES_HIGH  = 8'h79;
  localparam logic [7:0] ADDR_CTRL_A    = 8'h7A;
  localparam logic [7:0] ADDR_CTRL_B    = 8'h7B;
  localparam logic [7:0] ADDR_CHAN      = 8'h7C;
  localparam logic [7:0] ADDR_BUF_DIS   = 8'h7E;

  // Control A fields.
  localparam int         CA_ENABLE      = 7;
  localparam int         CA_START       = 6;
  localparam int         CA_AUTO        = 5;
  localparam int         CA_FLAG        = 4;
  localparam int         CA_IRQ_EN      = 3;
  localparam int         CA_DIV_HI      = 2;
  // Control B fields; bits 7 and 5:3 are reserved.
  localparam int         CB_CMP_MUX     = 6;
  localparam int         CB_TRIG_HI     = 2;
  // Channel register fields.
  localparam int         CH_LEFT        = 5;
  localparam int         CH_SEL_HI      = 4;

  localparam logic [7:0] RESET_BYTE     = 8'h00;
  localparam logic [9:0] RESET_RESULT   = 10'h000;
  localparam logic [2:0] TRIG_FREE      = 3'h0;
  localparam logic [4:0] DIFF_FIRST     = 5'h08;
  localparam logic [4:0] DIFF_LAST      = 5'h1D;
  localparam logic [6:0] PRESCALE_ZERO  = 7'h00;
  localparam logic [6:0] PRESCALE_ONE   = 7'h01;

  typedef enum logic [1:0] {
    ACR_IDLE    = 2'b00,
    ACR_CONVERT = 2'b01
  } acr_state_t;
endpackage : acr_pkg

// ---- src/acr_prescaler.sv ----
// Purpose: Free-running divider giving a one-cycle converter clock enable.
// Assumes: Divide select may change at any time.
// Notes:   The counter is never cleared, so a new divisor takes effect at once.
`timescale 1ns/10ps
module acr_prescaler (
  input  wire logic       sys_clk,
  input  wire logic       reset,
  input  wire logic [2:0] divSel,
  output logic            tick
);
  logic [6:0] count_q;
  logic [6:0] gapCnt_q;
  logic       gapValid_q;
  logic [2:0] divSelPrev_q;

  // Codes 0 and 1 both divide by two.
  function automatic logic [6:0] divMask(input logic [2:0] sel);
    logic [6:0] m;
    m = acr_pkg::PRESCALE_ONE;
    if (sel > 3'h1) begin
      m = 7'((8'h01 << sel) - 8'h01);
    end
    return m;
  endfunction : divMask

  always_ff @(posedge sys_clk) begin
    if (reset) count_q <= acr_pkg::PRESCALE_ZERO;
    else count_q <= count_q + acr_pkg::PRESCALE_ONE;
  end

  always_ff @(posedge sys_clk) begin
    if (reset) tick <= 1'b0;
    else tick <= ((count_q & divMask(divSel)) == divMask(divSel)); // [RULE2] [RULE21]
  end

  // Helper logic: distance between enables while the divisor is steady.
  always_ff @(posedge sys_clk) begin
    if (reset || divSel != divSelPrev_q) begin
      gapCnt_q   <= acr_pkg::PRESCALE_ONE;
      gapValid_q <= 1'b0;
    end else if (tick) begin
      gapCnt_q   <= acr_pkg::PRESCALE_ONE;
      gapValid_q <= 1'b1;
    end else begin
      gapCnt_q   <= gapCnt_q + acr_pkg::PRESCALE_ONE;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) divSelPrev_q <= 3'h0;
    else divSelPrev_q <= divSel;
  end

  property p_divide;
    @(posedge sys_clk) disable iff (reset)
      (tick && gapValid_q && divSel == divSelPrev_q) |-> (gapCnt_q == divMask(divSel) + acr_pkg::PRESCALE_ONE);
  endproperty
  a_divide: assert property (p_divide) else $error("Converter clock enable spacing wrong."); // [RULE2]
endmodule : acr_prescaler

// ---- src/acr_trigger.sv ----
// Purpose: Selects the auto-trigger source and finds its rising edge.
// Assumes: Source flags are levels synchronous to sys_clk.
// Notes:   A switch of source can itself make an edge, except into free running.
`timescale 1ns/10ps
module acr_trigger (
  input  wire logic       sys_clk,
  input  wire logic       reset,
  input  wire logic [2:0] trigSel,
  input  wire logic       doneFlag,
  input  wire logic [7:1] srcFlags,
  output logic            trigEdge
);
  logic       selected;
  logic       selectedPrev_q;
  logic [2:0] trigSelPrev_q;
  logic       intoFree;

  // Code zero follows the done flag itself, which keeps conversions running only while the flag is cleared after each one.
  always_comb begin
    selected = doneFlag;
    if (trigSel != acr_pkg::TRIG_FREE) selected = srcFlags[trigSel]; // [RULE14]
  end

  assign intoFree = (trigSel == acr_pkg::TRIG_FREE) && (trigSelPrev_q != acr_pkg::TRIG_FREE);
  assign trigEdge = selected && !selectedPrev_q && !intoFree; // [RULE12] [RULE13]

  always_ff @(posedge sys_clk) begin
    if (reset) selectedPrev_q <= 1'b0;
    else selectedPrev_q <= selected;
  end

  always_ff @(posedge sys_clk) begin
    if (reset) trigSelPrev_q <= acr_pkg::TRIG_FREE;
    else trigSelPrev_q <= trigSel;
  end

  property p_no_free_edge;
    @(posedge sys_clk) disable iff (reset)
      (trigSel == acr_pkg::TRIG_FREE && $past(trigSel) != acr_pkg::TRIG_FREE) |-> !trigEdge;
  endproperty
  a_no_free_edge: assert property (p_no_free_edge) else $error("Switch to free running made a trigger."); // [RULE13]
endmodule : acr_trigger

// ---- test/acr_control_bench.sv ----
// Purpose: Self-checking bench for the converter control and result registers.
// Assumes: The conversion core model answers after eight converter clock enables.
// Notes:   Starts are counted on the core link so that missing or extra triggers are both seen.
`timescale 1ns/10ps
module acr_control_bench;
  logic       sys_clk;
  logic       reset;
  logic [7:0] regAddr;
  logic [7:0] regWrData;
  logic       regWrEn;
  logic       regRdEn;
  logic [7:0] regRdData;
  logic       globalIrqEnable;
  logic       irqVectorTaken;
  logic       convIrq;
  logic [7:1] trigSrcFlags;
  logic       coreEnable;
  logic       coreStart;
  logic [4:0] coreChannel;
  logic       coreClkEnable;
  logic [9:0] coreResult;
  logic       coreDone;
  logic [7:0] pinRaw;
  logic [7:0] pinValue;
  logic [7:0] bufferDisable;
  logic [9:0] nextResult;
  int         err_count;
  int         num_checks;
  int         startCount;
  int         cycleCount;
  int         s;
  int         n;
  logic [7:0] d;

  acr_control u_dut (.sys_clk(sys_clk), .reset(reset), .regAddr(regAddr), .regWrData(regWrData),
    .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData), .globalIrqEnable(globalIrqEnable),
    .irqVectorTaken(irqVectorTaken), .convIrq(convIrq), .trigSrcFlags(trigSrcFlags), .coreEnable(coreEnable),
    .coreStart(coreStart), .coreChannel(coreChannel), .coreClkEnable(coreClkEnable), .coreResult(coreResult),
    .coreDone(coreDone), .pinRaw(pinRaw), .pinValue(pinValue), .bufferDisable(bufferDisable));

  acr_core_model #(.CONV_TICKS(8)) u_core (.sys_clk(sys_clk), .reset(reset), .coreEnable(coreEnable),
    .coreStart(coreStart), .coreClkEnable(coreClkEnable), .nextResult(nextResult), .coreResult(coreResult),
    .coreDone(coreDone));

  always #5 sys_clk = ~sys_clk;

  always @(posedge sys_clk) begin
    if (coreStart === 1'b1) startCount <= startCount + 1;
    cycleCount <= cycleCount + 1;
    if (cycleCount == 20000) begin
      err_count++;
      summarize();
    end
  end

  task automatic summarize();
    if (err_count == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : summarize

  task automatic chkByte(input string nm, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chkByte

  task automatic chkBit(input string nm, input logic e, input logic g);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s expected %b seen %b", nm, e, g);
    end
  endtask : chkBit

  task automatic wrReg(input logic [7:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    regAddr   <= a;
    regWrData <= v;
    regWrEn   <= 1'b1;
    @(posedge sys_clk);
    regWrEn   <= 1'b0;
  endtask : wrReg

  task automatic rdReg(input logic [7:0] a, output logic [7:0] v);
    @(posedge sys_clk);
    regAddr <= a;
    regRdEn <= 1'b1;
    @(posedge sys_clk);
    regRdEn <= 1'b0;
    #1 v = regRdData;
  endtask : rdReg

  task automatic chkReg(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] v;
    rdReg(a, v);
    chkByte("register read", e, v);
  endtask : chkReg

  task automatic waitCycles(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask : waitCycles

  task automatic waitDone();
    int k;
    k = 0;
    do begin
      @(posedge sys_clk);
      #1 k++;
    end while (coreDone !== 1'b1 && k < 500);
    chkBit("conversion done seen", 1'b1, coreDone);
    waitCycles(2);
  endtask : waitDone

  task automatic waitTick(output int k);
    k = 0;
    do begin
      @(posedge sys_clk);
      #1 k++;
    end while (coreClkEnable !== 1'b1 && k < 300);
  endtask : waitTick

  // Raw result from the core, then a start written with the given control A settings.
  task automatic convert(input logic [9:0] r, input logic [7:0] ctrl);
    @(posedge sys_clk);
    nextResult <= r;
    wrReg(acr_pkg::ADDR_CTRL_A, ctrl | 8'h40);
    waitDone();
  endtask : convert

  initial begin
    sys_clk = 1'b0;
    reset = 1'b1;
    regAddr = 8'h00;
    regWrData = 8'h00;
    regWrEn = 1'b0;
    regRdEn = 1'b0;
    globalIrqEnable = 1'b1;
    irqVectorTaken = 1'b0;
    trigSrcFlags = 7'h00;
    pinRaw = 8'h00;
    nextResult = 10'h000;
    err_count = 0;
    num_checks = 0;
    startCount = 0;
    cycleCount = 0;
    repeat (6) @(posedge sys_clk);
    reset <= 1'b0;
    foreach (d[i]) chkReg(8'h78 + 8'(i), 8'h00);
    wrReg(acr_pkg::ADDR_RES_LOW, 8'hFF);
    chkReg(acr_pkg::ADDR_RES_LOW, 8'h00);
    wrReg(acr_pkg::ADDR_RES_HIGH, 8'hFF);
    chkReg(acr_pkg::ADDR_RES_HIGH, 8'h00);
    wrReg(8'h7D, 8'hFF);
    chkReg(8'h7D, 8'h00);
    wrReg(acr_pkg::ADDR_CTRL_B, 8'h47);
    chkReg(acr_pkg::ADDR_CTRL_B, 8'h47);
    wrReg(acr_pkg::ADDR_CTRL_B, 8'h00);
    for (int c = 0; c < 8; c++) begin
      wrReg(acr_pkg::ADDR_CTRL_A, 8'h80 | 8'(c));
      waitTick(n);
      waitTick(n);
      waitTick(n);
      chkByte("divider period", (c < 2) ? 8'h02 : 8'(1 << c), 8'(n));
    end
    // Single-ended conversion, interrupt gating and both alignments.
    convert(10'h2A5, 8'h80);
    chkBit("irq without enable", 1'b0, convIrq);
    chkReg(acr_pkg::ADDR_CTRL_A, 8'h90);
    wrReg(acr_pkg::ADDR_CTRL_A, 8'h88);
    waitCycles(2);
    chkBit("irq enabled", 1'b1, convIrq);
    @(posedge sys_clk) globalIrqEnable <= 1'b0;
    waitCycles(2);
    chkBit("irq global off", 1'b0, convIrq);
    @(posedge sys_clk) globalIrqEnable <= 1'b1;
    @(posedge sys_clk) irqVectorTaken <= 1'b1;
    @(posedge sys_clk) irqVectorTaken <= 1'b0;
    waitCycles(2);
    chkBit("irq after vector", 1'b0, convIrq);
    chkReg(acr_pkg::ADDR_CTRL_A, 8'h88);
    chkReg(acr_pkg::ADDR_RES_LOW, 8'hA5);
    chkReg(acr_pkg::ADDR_RES_HIGH, 8'h02);
    wrReg(acr_pkg::ADDR_CHAN, 8'h20);
    chkReg(acr_pkg::ADDR_RES_HIGH, 8'hA9);
    chkReg(acr_pkg::ADDR_RES_LOW, 8'h40);
    chkReg(acr_pkg::ADDR_RES_HIGH, 8'hA9);
    wrReg(acr_pkg::ADDR_CHAN, 8'h00);
    // Busy bit, ignored zero write, then the low-byte lock.
    @(posedge sys_clk) nextResult <= 10'h155;
    wrReg(acr_pkg::ADDR_CTRL_A, 8'hC8);
    chkReg(acr_pkg::ADDR_CTRL_A, 8'hC8);
    wrReg(acr_pkg::ADDR_CTRL_A, 8'h88);
    chkReg(acr_pkg::ADDR_CTRL_A, 8'hC8);
    waitDone();
    chkReg(acr_pkg::ADDR_RES_LOW, 8'h55);
    wrReg(acr_pkg::ADDR_CTRL_A, 8'h98);
    chkReg(acr_pkg::ADDR_CTRL_A, 8'h88);
    convert(10'h0F0, 8'h88);
    chkReg(acr_pkg::ADDR_CTRL_A, 8'h88);
    chkReg(acr_pkg::ADDR_RES_HIGH, 8'h01);
    convert(10'h0F0, 8'h88);
    chkReg(acr_pkg::ADDR_RES_LOW, 8'hF0);
    chkReg(acr_pkg::ADDR_RES_HIGH, 8'h00);
    // Differential pairs at both ends of their range.
    wrReg(acr_pkg::ADDR_CHAN, {3'h0, acr_pkg::DIFF_FIRST});
    convert(10'h005, 8'h80);
    chkReg(acr_pkg::ADDR_RES_LOW, 8'h05);
    chkReg(acr_pkg::ADDR_RES_HIGH, 8'h02);
    wrReg(acr_pkg::ADDR_CHAN, {3'h0, acr_pkg::DIFF_LAST});
    convert(10'h3FF, 8'h80);
    chkReg(acr_pkg::ADDR_RES_LOW, 8'hFF);
    chkReg(acr_pkg::ADDR_RES_HIGH, 8'h01);
    // Auto trigger from every flag source; an unselected source must not start.
    wrReg(acr_pkg::ADDR_CTRL_A, 8'hA0);
    for (int k = 1; k < 8; k++) begin
      wrReg(acr_pkg::ADDR_CTRL_B, 8'(k));
      s = startCount;
      @(posedge sys_clk) trigSrcFlags <= 7'(1 << (k % 7));
      waitCycles(6);
      chkByte("starts from other source", 8'(s), 8'(startCount));
      @(posedge sys_clk) trigSrcFlags <= 7'(1 << (k % 7)) | 7'(1 << (k - 1));
      waitCycles(6);
      chkByte("starts from selected source", 8'(s + 1), 8'(startCount));
      waitDone();
      @(posedge sys_clk) trigSrcFlags <= 7'h00;
    end
    @(posedge sys_clk) trigSrcFlags <= 7'h04;
    s = startCount;
    wrReg(acr_pkg::ADDR_CTRL_B, 8'h03);
    waitCycles(6);
    chkByte("starts on source switch", 8'(s + 1), 8'(startCount));
    waitDone();
    @(posedge sys_clk) trigSrcFlags <= 7'h00;
    wrReg(acr_pkg::ADDR_CTRL_B, 8'h00);
    waitCycles(6);
    chkByte("starts on switch to free run", 8'(s + 1), 8'(startCount));
    wrReg(acr_pkg::ADDR_CTRL_A, 8'h80);
    wrReg(acr_pkg::ADDR_CTRL_B, 8'h03);
    @(posedge sys_clk) trigSrcFlags <= 7'h00;
    @(posedge sys_clk) trigSrcFlags <= 7'h04;
    waitCycles(6);
    chkByte("starts with auto off", 8'(s + 1), 8'(startCount));
    // Clearing the enable mid-conversion aborts it with no flag and no new result.
    @(posedge sys_clk) nextResult <= 10'h3C3;
    wrReg(acr_pkg::ADDR_CTRL_A, 8'hD0);
    chkReg(acr_pkg::ADDR_CTRL_A, 8'hC0);
    chkBit("core enable", 1'b1, coreEnable);
    chkByte("core channel", {3'h0, acr_pkg::DIFF_LAST}, {3'h0, coreChannel});
    wrReg(acr_pkg::ADDR_CTRL_A, 8'h00);
    waitCycles(20);
    chkBit("core enable off", 1'b0, coreEnable);
    chkReg(acr_pkg::ADDR_CTRL_A, 8'h00);
    chkReg(acr_pkg::ADDR_RES_LOW, 8'hFF);
    chkReg(acr_pkg::ADDR_RES_HIGH, 8'h01);
    // Digital input buffers of pins carrying analog signals switched off.
    @(posedge sys_clk) pinRaw <= 8'hFF;
    wrReg(acr_pkg::ADDR_BUF_DIS, 8'h5A);
    waitCycles(2);
    chkByte("pin value", 8'hA5, pinValue);
    chkByte("buffer disable", 8'h5A, bufferDisable);
    chkReg(acr_pkg::ADDR_BUF_DIS, 8'h5A);
    summarize();
  end
endmodule : acr_control_bench

// ---- test/acr_core_model.sv ----
// Purpose: Behavioural conversion core standing on the far side of the control block.
// Assumes: A conversion lasts CONV_TICKS converter clock enables after the start pulse.
// Notes:   The result bus carries the inverted value outside the done cycle, so a late sample is seen as wrong.
`timescale 1ns/10ps
module acr_core_model #(
  parameter int CONV_TICKS = 8
) (
  input  wire logic       sys_clk,
  input  wire logic       reset,
  input  wire logic       coreEnable,
  input  wire logic       coreStart,
  input  wire logic       coreClkEnable,
  input  wire logic [9:0] nextResult,
  output logic      [9:0] coreResult,
  output logic            coreDone
);
  int   ticksLeft;
  logic busy;

  // Dropping the enable aborts a running conversion without a done strobe.
  always @(posedge sys_clk) begin
    coreDone <= 1'b0;
    if (reset || !coreEnable) begin
      busy      <= 1'b0;
      ticksLeft <= 0;
    end else if (coreStart && !busy) begin
      busy      <= 1'b1;
      ticksLeft <= CONV_TICKS;
    end else if (busy && coreClkEnable) begin
      if (ticksLeft == 1) begin
        busy     <= 1'b0;
        coreDone <= 1'b1;
      end
      ticksLeft <= ticksLeft - 1;
    end
  end

  assign coreResult = coreDone ? nextResult : ~nextResult;
endmodule : acr_core_model
